// file: rtl/brbm_defs.svh
// Address map, field and reset constants for the boot remap bus matrix.
`ifndef BRBM_DEFS_SVH
`define BRBM_DEFS_SVH
`define BRBM_BOOT_BASE 32'h0000_0000
`define BRBM_FLASH_BASE 32'h0800_0000
`define BRBM_SYSMEM_BASE 32'h1fff_ec00
`define BRBM_SRAM_BASE 32'h2000_0000
`define BRBM_GPIO_BASE 32'h4800_0000
`define BRBM_PERIPH_BASE 32'h4000_0000
`define BRBM_BOOT_SIZE 32'h0001_0000
`define BRBM_FLASH_SIZE 32'h0001_0000
`define BRBM_SYSMEM_SIZE 32'h0000_0c00
`define BRBM_SRAM_SIZE 32'h0000_2000
`define BRBM_GPIO_SIZE 32'h0000_2000
`define BRBM_PERIPH_SIZE 32'h0002_0000
`define BRBM_MAP_FLASH 2'h0
`define BRBM_MAP_SYSMEM 2'h1
`define BRBM_MAP_SRAM 2'h3
`define BRBM_SIZE_BYTE 2'h0
`define BRBM_SIZE_HALF 2'h1
`define BRBM_SIZE_WORD 2'h2
`endif

// file: rtl/brbm_pkg.sv
// Types shared by the boot remap bus matrix.
package brbm_pkg;
    typedef enum logic [3:0] {
        brbm_slv_sram = 4'h1,
        brbm_slv_flash = 4'h2,
        brbm_slv_gpio = 4'h4,
        brbm_slv_periph = 4'h8
    } brbm_slave_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } brbm_req_type;

    typedef struct packed {
        logic ready;
        logic error;
        logic [31:0] rdata;
    } brbm_rsp_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [1:0] size;
        logic [3:0] strobe;
        logic [31:0] addr;
        logic [31:0] wdata;
    } brbm_slv_req_type;
endpackage

// file: rtl/brbm_decoder.sv
// Address decoder that applies the boot space remapping.
`timescale 1ns/1ns
`include "brbm_defs.svh"
module brbm_decoder (
    input wire logic [31:0] addr,
    input wire logic [1:0] memory_map_select,
    output logic hit,
    output brbm_pkg::brbm_slave_type slave,
    output logic [31:0] phys_addr
);
    function automatic logic in_range(input logic [31:0] a,
                                      input logic [31:0] base,
                                      input logic [31:0] size);
        in_range = (a >= base) && (a - base < size);
    endfunction

    always_comb begin
        hit = 1'b1;
        slave = brbm_pkg::brbm_slv_flash;
        phys_addr = addr;
        if (in_range(addr, `BRBM_BOOT_BASE, `BRBM_BOOT_SIZE)) begin
            case (memory_map_select)
                `BRBM_MAP_FLASH: begin
                    phys_addr = addr + `BRBM_FLASH_BASE;
                end
                `BRBM_MAP_SYSMEM: begin
                    hit = (addr < `BRBM_SYSMEM_SIZE);
                    phys_addr = addr + `BRBM_SYSMEM_BASE;
                end
                `BRBM_MAP_SRAM: begin
                    // SRAM boot leaves no alias; code must run from the base.
                    hit = 1'b0;
                end
                default: begin
                    hit = 1'b0;
                end
            endcase
        end else if (in_range(addr, `BRBM_FLASH_BASE, `BRBM_FLASH_SIZE)
                     || in_range(addr, `BRBM_SYSMEM_BASE,
                                 `BRBM_SYSMEM_SIZE)) begin
            slave = brbm_pkg::brbm_slv_flash;
        end else if (in_range(addr, `BRBM_SRAM_BASE, `BRBM_SRAM_SIZE)) begin
            slave = brbm_pkg::brbm_slv_sram;
        end else if (in_range(addr, `BRBM_GPIO_BASE, `BRBM_GPIO_SIZE)) begin
            slave = brbm_pkg::brbm_slv_gpio;
        end else if (in_range(addr, `BRBM_PERIPH_BASE,
                              `BRBM_PERIPH_SIZE)) begin
            slave = brbm_pkg::brbm_slv_periph;
        end else begin
            hit = 1'b0;
        end
    end
endmodule // brbm_decoder

// file: rtl/brbm_matrix.sv
// Two-master, four-slave bus matrix with boot remapping.
`timescale 1ns/1ns
`include "brbm_defs.svh"
module brbm_matrix (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic boot_select_pin,
    input wire logic boot_source_option_bit,
    input wire logic standby_exit,
    input wire logic map_write,
    input wire logic [1:0] map_wdata,
    output logic [1:0] memory_map_select,
    input wire brbm_pkg::brbm_req_type core_req,
    output brbm_pkg::brbm_rsp_type core_rsp,
    input wire brbm_pkg::brbm_req_type dma_req,
    output brbm_pkg::brbm_rsp_type dma_rsp,
    output brbm_pkg::brbm_slv_req_type slv_req,
    output logic [3:0] slv_sel,
    input wire logic slv_ready,
    input wire logic [31:0] slv_rdata
);
    typedef enum logic [3:0] {
        brbm_st_boot = 4'h1,
        brbm_st_idle = 4'h2,
        brbm_st_busy = 4'h4,
        brbm_st_err = 4'h8
    } brbm_state_type;

    function automatic logic [3:0] lane_strobe(input logic [1:0] size,
                                              input logic [1:0] ofs);
        case (size)
            `BRBM_SIZE_BYTE: lane_strobe = 4'h1 << ofs;
            `BRBM_SIZE_HALF: lane_strobe = ofs[1] ? 4'hc : 4'h3;
            default: lane_strobe = 4'hf;
        endcase
    endfunction

    function automatic logic [1:0] boot_map(input logic pin,
                                           input logic opt);
        if (!pin) begin
            boot_map = `BRBM_MAP_FLASH;
        end else if (opt) begin
            boot_map = `BRBM_MAP_SYSMEM;
        end else begin
            boot_map = `BRBM_MAP_SRAM;
        end
    endfunction

    brbm_state_type state, next_state;
    logic [1:0] next_memory_map_select;
    logic owner_dma, next_owner_dma;
    logic last_dma, next_last_dma;
    brbm_pkg::brbm_rsp_type next_core_rsp, next_dma_rsp;
    brbm_pkg::brbm_slv_req_type next_slv_req;
    logic [3:0] next_slv_sel;
    brbm_pkg::brbm_req_type pick;
    logic pick_dma;
    logic dec_hit;
    brbm_pkg::brbm_slave_type dec_slave;
    logic [31:0] dec_addr;

    brbm_decoder u_decoder (
        .addr(pick.addr),
        .memory_map_select(memory_map_select),
        .hit(dec_hit),
        .slave(dec_slave),
        .phys_addr(dec_addr)
    );

    // Round robin keeps a busy DMA from starving the core and vice versa.
    always_comb begin
        if (core_req.valid && dma_req.valid) begin
            pick_dma = !last_dma;
        end else begin
            pick_dma = dma_req.valid;
        end
        pick = pick_dma ? dma_req : core_req;
    end

    always_comb begin
        next_state = state;
        next_memory_map_select = memory_map_select;
        next_owner_dma = owner_dma;
        next_last_dma = last_dma;
        next_core_rsp = '0;
        next_dma_rsp = '0;
        next_slv_req = slv_req;
        next_slv_sel = slv_sel;
        case (state)
            brbm_st_boot: begin
                // Pin levels are taken only after reset release.
                next_memory_map_select = boot_map(boot_select_pin,
                    boot_source_option_bit);
                next_state = brbm_st_idle;
            end
            brbm_st_idle: begin
                if (standby_exit) begin
                    next_memory_map_select = boot_map(boot_select_pin,
                        boot_source_option_bit);
                end else if (map_write) begin
                    next_memory_map_select = map_wdata;
                end else if (core_req.valid || dma_req.valid) begin
                    next_owner_dma = pick_dma;
                    next_last_dma = pick_dma;
                    if (dec_hit) begin
                        next_slv_sel = dec_slave;
                        next_slv_req.valid = 1'b1;
                        next_slv_req.write = pick.write;
                        next_slv_req.addr = dec_addr;
                        next_slv_req.wdata = pick.wdata;
                        next_slv_req.size = pick.size;
                        next_slv_req.strobe = lane_strobe(pick.size,
                            dec_addr[1:0]);
                        if (dec_slave == brbm_pkg::brbm_slv_periph) begin
                            // Peripheral accesses always go out as aligned whole words.
                            next_slv_req.size = `BRBM_SIZE_WORD;
                            next_slv_req.strobe = 4'hf;
                            next_slv_req.addr = {dec_addr[31:2], 2'h0};
                        end
                        next_state = brbm_st_busy;
                    end else begin
                        next_state = brbm_st_err;
                    end
                end
            end
            brbm_st_busy: begin
                if (slv_ready) begin
                    next_slv_req.valid = 1'b0;
                    next_slv_sel = 4'h0;
                    next_core_rsp.ready = !owner_dma;
                    next_core_rsp.rdata = slv_rdata;
                    next_dma_rsp.ready = owner_dma;
                    next_dma_rsp.rdata = slv_rdata;
                    next_state = brbm_st_idle;
                end
            end
            brbm_st_err: begin
                next_core_rsp.ready = !owner_dma;
                next_core_rsp.error = !owner_dma;
                next_dma_rsp.ready = owner_dma;
                next_dma_rsp.error = owner_dma;
                next_state = brbm_st_idle;
            end
            default: begin
                next_state = brbm_st_idle;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= brbm_st_boot;
            memory_map_select <= `BRBM_MAP_FLASH;
            owner_dma <= 1'b0;
            last_dma <= 1'b0;
            core_rsp <= '0;
            dma_rsp <= '0;
            slv_req <= '0;
            slv_sel <= 4'h0;
        end else if (clk_en) begin
            state <= next_state;
            memory_map_select <= next_memory_map_select;
            owner_dma <= next_owner_dma;
            last_dma <= next_last_dma;
            core_rsp <= next_core_rsp;
            dma_rsp <= next_dma_rsp;
            slv_req <= next_slv_req;
            slv_sel <= next_slv_sel;
        end
    end

    sequence boot_done_s;
        state == brbm_st_boot ##1 state == brbm_st_idle;
    endsequence

    sequence taken_s;
        state == brbm_st_idle && clk_en && !standby_exit && !map_write &&
        (core_req.valid || dma_req.valid);
    endsequence

    boot_map_init_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_boot && clk_en) |=> memory_map_select ==
        boot_map($past(boot_select_pin), $past(boot_source_option_bit)))
        else $error("map select not taken from pins");
    pin_low_flash_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_boot && clk_en && !boot_select_pin) |=>
        memory_map_select == `BRBM_MAP_FLASH)
        else $error("pin low did not map flash");
    sysmem_map_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_boot && clk_en && boot_select_pin &&
        boot_source_option_bit) |=> memory_map_select == `BRBM_MAP_SYSMEM)
        else $error("system memory not mapped");
    sram_map_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_boot && clk_en && boot_select_pin &&
        !boot_source_option_bit) |=> memory_map_select == `BRBM_MAP_SRAM)
        else $error("sram not mapped");
    boot_leaves_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_boot && clk_en) |-> boot_done_s)
        else $error("boot step not single");
    map_write_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_idle && clk_en && !standby_exit && map_write) |=>
        memory_map_select == $past(map_wdata))
        else $error("software map write lost");
    standby_latch_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_idle && clk_en && standby_exit) |=>
        memory_map_select == boot_map($past(boot_select_pin),
        $past(boot_source_option_bit)))
        else $error("standby exit not latched");
    periph_word_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (slv_req.valid && slv_sel == brbm_pkg::brbm_slv_periph) |->
        (slv_req.strobe == 4'hf && slv_req.size == `BRBM_SIZE_WORD))
        else $error("peripheral access not widened");
    one_owner_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !(core_rsp.ready && dma_rsp.ready))
        else $error("both masters answered at once");
    fair_grant_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_idle && clk_en && !standby_exit && !map_write &&
        core_req.valid && dma_req.valid) |=> owner_dma != $past(last_dma))
        else $error("arbitration not alternating");
    sram_native_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (slv_req.valid && slv_sel == brbm_pkg::brbm_slv_sram) |->
        slv_req.addr >= `BRBM_SRAM_BASE)
        else $error("sram decoded below its base");

    // Transfer steps, checked apart from the decoder's own view.
    take_step_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        taken_s |=>
        (state == brbm_st_busy || state == brbm_st_err))
        else $error("taken request did not move on");
    sram_no_alias_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_idle && clk_en && !standby_exit && !map_write &&
        pick.valid && memory_map_select == `BRBM_MAP_SRAM &&
        pick.addr < `BRBM_BOOT_SIZE) |=> state == brbm_st_err)
        else $error("sram answered at boot space");
    slv_hold_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (slv_req.valid && !slv_ready && clk_en) |=>
        ($stable(slv_req) && $stable(slv_sel)))
        else $error("slave request changed before answer");
    rsp_pulse_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (clk_en && (core_rsp.ready || dma_rsp.ready)) |=>
        (!core_rsp.ready && !dma_rsp.ready))
        else $error("master answer stood too long");
    rdata_pass_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_busy && slv_ready && clk_en) |=>
        (core_rsp.rdata == $past(slv_rdata)))
        else $error("read data not passed back");
    miss_error_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (state == brbm_st_err && clk_en) |=>
        (core_rsp.error || dma_rsp.error))
        else $error("decode miss not reported");
    sel_onehot_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        slv_req.valid |->
        $onehot(slv_sel))
        else $error("slave select not one-hot");
    byte_lane_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (slv_req.valid && slv_sel == brbm_pkg::brbm_slv_sram &&
        slv_req.size == `BRBM_SIZE_BYTE) |-> $onehot(slv_req.strobe))
        else $error("byte access not on one lane");
    half_lane_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (slv_req.valid && slv_sel == brbm_pkg::brbm_slv_sram &&
        slv_req.size == `BRBM_SIZE_HALF) |->
        (slv_req.strobe == 4'h3 || slv_req.strobe == 4'hc))
        else $error("halfword access on wrong lanes");
    periph_align_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (slv_req.valid && slv_sel == brbm_pkg::brbm_slv_periph) |->
        slv_req.addr[1:0] == 2'h0)
        else $error("peripheral access not word aligned");
    flash_window_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        (slv_req.valid && slv_sel == brbm_pkg::brbm_slv_flash) |->
        (slv_req.addr - `BRBM_FLASH_BASE < `BRBM_FLASH_SIZE ||
        slv_req.addr - `BRBM_SYSMEM_BASE < `BRBM_SYSMEM_SIZE))
        else $error("flash slave given a foreign address");
    // A low enable must not let the map or the sequencer creep forward.
    freeze_a: assert property (
        @(posedge mclk) disable iff (!reset_n)
        !clk_en |=>
        ($stable(state) && $stable(memory_map_select)))
        else $error("state moved while clock enable low");
endmodule // brbm_matrix

// file: tb/brbm_slave_model.sv
// Slave side model that answers the bus matrix after a chosen delay.
`timescale 1ns/1ns
module brbm_slave_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire brbm_pkg::brbm_slv_req_type slv_req,
    input wire logic [3:0] slv_sel,
    input wire logic [3:0] delay,
    output logic slv_ready,
    output logic [31:0] slv_rdata,
    output brbm_pkg::brbm_slv_req_type seen_req,
    output logic [3:0] seen_sel
);
    logic [3:0] cnt;
    logic [31:0] val;
    assign val = seen_req.addr ^ 32'h5a5a_0000;
    // Outside the answer cycle the data lines show the inverse, so a stale
    // word can never pass for a fresh one.
    assign slv_rdata = slv_ready ? val : ~val;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            slv_ready <= 1'b0;
            seen_req <= '0;
            seen_sel <= 4'h0;
        end else begin
            slv_ready <= 1'b0;
            if (slv_req.valid && !slv_ready) begin
                if (cnt >= delay) begin
                    slv_ready <= 1'b1;
                    cnt <= 4'h0;
                    seen_req <= slv_req;
                    seen_sel <= slv_sel;
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule // brbm_slave_model

// file: tb/boot_remap_bus_matrix_tb.sv
// Self-checking testbench for the boot remap bus matrix.
`timescale 1ns/1ns
module boot_remap_bus_matrix_tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic pin = 1'b0;
    logic opt = 1'b0;
    logic standby_exit = 1'b0;
    logic map_write = 1'b0;
    logic [1:0] map_wdata = 2'h0;
    logic [1:0] memory_map_select;
    brbm_pkg::brbm_req_type core_req = '0;
    brbm_pkg::brbm_req_type dma_req = '0;
    brbm_pkg::brbm_rsp_type core_rsp;
    brbm_pkg::brbm_rsp_type dma_rsp;
    brbm_pkg::brbm_slv_req_type slv_req;
    brbm_pkg::brbm_slv_req_type seen_req;
    logic [3:0] slv_sel;
    logic [3:0] seen_sel;
    logic [3:0] delay = 4'h0;
    logic slv_ready;
    logic [31:0] slv_rdata;
    int n_errors = 0;
    int total_checks = 0;
    always #10 mclk = ~mclk;
    brbm_matrix dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
        .boot_select_pin(pin), .boot_source_option_bit(opt),
        .standby_exit(standby_exit), .map_write(map_write),
        .map_wdata(map_wdata), .memory_map_select(memory_map_select),
        .core_req(core_req), .core_rsp(core_rsp), .dma_req(dma_req),
        .dma_rsp(dma_rsp), .slv_req(slv_req), .slv_sel(slv_sel),
        .slv_ready(slv_ready), .slv_rdata(slv_rdata));
    brbm_slave_model slave_u (.mclk(mclk), .reset_n(reset_n),
        .slv_req(slv_req), .slv_sel(slv_sel), .delay(delay),
        .slv_ready(slv_ready), .slv_rdata(slv_rdata),
        .seen_req(seen_req), .seen_sel(seen_sel));
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // A selected slave of 0 means the access must end in an error.
    task automatic xfer(input int m, input logic wr, input logic [1:0] sz,
        input logic [31:0] a, input logic [3:0] es, input logic [31:0] ea,
        input logic [3:0] eb);
        brbm_pkg::brbm_req_type r;
        brbm_pkg::brbm_rsp_type s;
        int n;
        r = '{1'b1, wr, sz, a, a ^ 32'h0f0f_0f0f};
        @(negedge mclk);
        if (m == 0) core_req = r;
        else dma_req = r;
        n = 0;
        do begin
            @(posedge mclk);
            #1;
            s = (m == 0) ? core_rsp : dma_rsp;
            n++;
        end while (s.ready !== 1'b1 && n < 40);
        @(negedge mclk);
        if (m == 0) core_req.valid = 1'b0;
        else dma_req.valid = 1'b0;
        check("ready", {31'h0, s.ready}, 32'h1);
        check("error", {31'h0, s.error}, {31'h0, es == 4'h0});
        if (es != 4'h0) begin
            check("sel", {28'h0, seen_sel}, {28'h0, es});
            check("addr", seen_req.addr, ea);
            check("strobe", {28'h0, seen_req.strobe}, {28'h0, eb});
            check("dir", {31'h0, seen_req.write}, {31'h0, wr});
            if (!wr) check("rdata", s.rdata, ea ^ 32'h5a5a_0000);
            if (wr && sz == 2'h2) begin
                check("wdata", seen_req.wdata, r.wdata);
            end
        end
    endtask
    task automatic boot(input logic p, input logic o, input logic [1:0] em);
        @(negedge mclk);
        reset_n = 1'b0;
        pin = p;
        opt = o;
        repeat (8) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        check("map", {30'h0, memory_map_select}, {30'h0, em});
    endtask
    task automatic set_map(input logic [1:0] v);
        @(negedge mclk);
        map_write = 1'b1;
        map_wdata = v;
        @(negedge mclk);
        map_write = 1'b0;
        @(negedge mclk);
        check("map", {30'h0, memory_map_select}, {30'h0, v});
    endtask
    task automatic t_boot_modes();
        boot(1'b0, 1'b1, 2'h0);
        xfer(0, 1'b0, 2'h2, 32'h10, 4'h2, 32'h0800_0010, 4'hf);
        xfer(1, 1'b0, 2'h2, 32'h0800_0010, 4'h2, 32'h0800_0010, 4'hf);
        boot(1'b1, 1'b1, 2'h1);
        xfer(0, 1'b0, 2'h2, 32'h10, 4'h2, 32'h1fff_ec10, 4'hf);
        xfer(0, 1'b0, 2'h2, 32'h1fff_ec10, 4'h2, 32'h1fff_ec10, 4'hf);
        boot(1'b1, 1'b0, 2'h3);
        xfer(0, 1'b0, 2'h2, 32'h10, 4'h0, 32'h0, 4'h0);
        xfer(1, 1'b0, 2'h2, 32'h2000_0010, 4'h1, 32'h2000_0010, 4'hf);
        boot(1'b0, 1'b0, 2'h0);
    endtask
    task automatic t_sizes();
        xfer(0, 1'b1, 2'h0, 32'h2000_0003, 4'h1, 32'h2000_0003, 4'h8);
        xfer(1, 1'b1, 2'h1, 32'h2000_0002, 4'h1, 32'h2000_0002, 4'hc);
        xfer(0, 1'b0, 2'h1, 32'h2000_0000, 4'h1, 32'h2000_0000, 4'h3);
        xfer(0, 1'b0, 2'h0, 32'h2000_0001, 4'h1, 32'h2000_0001, 4'h2);
        xfer(1, 1'b1, 2'h2, 32'h2000_0004, 4'h1, 32'h2000_0004, 4'hf);
        xfer(0, 1'b0, 2'h0, 32'h4000_0005, 4'h8, 32'h4000_0004, 4'hf);
        check("psize", {30'h0, seen_req.size}, 32'h2);
        xfer(1, 1'b1, 2'h1, 32'h4000_0012, 4'h8, 32'h4000_0010, 4'hf);
        check("psize", {30'h0, seen_req.size}, 32'h2);
        xfer(0, 1'b1, 2'h0, 32'h4800_0001, 4'h4, 32'h4800_0001, 4'h2);
    endtask
    task automatic t_remap();
        set_map(2'h1);
        xfer(0, 1'b0, 2'h2, 32'h20, 4'h2, 32'h1fff_ec20, 4'hf);
        set_map(2'h3);
        xfer(1, 1'b0, 2'h2, 32'h20, 4'h0, 32'h0, 4'h0);
        set_map(2'h2);
        xfer(0, 1'b0, 2'h2, 32'h20, 4'h0, 32'h0, 4'h0);
        set_map(2'h0);
        xfer(0, 1'b0, 2'h2, 32'h20, 4'h2, 32'h0800_0020, 4'hf);
    endtask
    task automatic pulse_exit(input logic [1:0] em);
        @(negedge mclk);
        standby_exit = 1'b1;
        @(negedge mclk);
        standby_exit = 1'b0;
        @(negedge mclk);
        check("map", {30'h0, memory_map_select}, {30'h0, em});
    endtask
    task automatic t_standby();
        pin = 1'b1;
        opt = 1'b1;
        pulse_exit(2'h1);
        pin = 1'b0;
        repeat (3) @(negedge mclk);
        check("map", {30'h0, memory_map_select}, 32'h1);
        pulse_exit(2'h0);
    endtask
    // The last grant before this went to the core, so round robin hands
    // the first slot to the DMA and the core follows.
    task automatic t_concurrent();
        time tc;
        time td;
        delay = 4'h3;
        fork
            begin
                xfer(0, 1'b0, 2'h2, 32'h2000_0100, 4'h1,
                    32'h2000_0100, 4'hf);
                tc = $time;
            end
            begin
                xfer(1, 1'b0, 2'h2, 32'h2000_0200, 4'h1,
                    32'h2000_0200, 4'hf);
                td = $time;
            end
        join
        check("order", {31'h0, td < tc}, 32'h1);
        delay = 4'h0;
    endtask
    // A pending map write must wait until the clock enable returns.
    task automatic t_freeze();
        @(negedge mclk);
        clk_en = 1'b0;
        map_write = 1'b1;
        map_wdata = 2'h1;
        repeat (3) @(negedge mclk);
        check("frozen", {30'h0, memory_map_select}, 32'h0);
        clk_en = 1'b1;
        @(negedge mclk);
        map_write = 1'b0;
        check("thawed", {30'h0, memory_map_select}, 32'h1);
        set_map(2'h0);
    endtask
    initial begin
        t_boot_modes();
        t_sizes();
        t_remap();
        t_standby();
        t_concurrent();
        t_freeze();
        finish_test();
    end
    // The whole sequence needs well under a thousand cycles.
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        finish_test();
    end
endmodule // boot_remap_bus_matrix_tb
